// File: cpwf_pkg.sv
// Package of the CAN physical layer wake-up and fault control block.
// Assumes an AXI4-Lite register bus with 32-bit data on aclk.
package cpwf_pkg;
	// ========================================================================
	// Register byte offsets.
	localparam logic [7:0] CPWF_OFS_CTRL = 8'h00;
	localparam logic [7:0] CPWF_OFS_STAT = 8'h04;
	localparam logic [7:0] CPWF_OFS_FLAG = 8'h08;
	localparam logic [7:0] CPWF_OFS_MASK = 8'h0C;
	// ========================================================================
	// Control register fields.
	localparam int CPWF_CTRL_WUP_LSB = 0;
	localparam int CPWF_CTRL_EN_BIT = 2;
	localparam logic [2:0] CPWF_CTRL_RST = 3'h0;
	// ========================================================================
	// Wake-up select encodings.
	localparam logic [1:0] CPWF_WUP_OFF = 2'h0;
	localparam logic [1:0] CPWF_WUP_MASK1 = 2'h1;
	localparam logic [1:0] CPWF_WUP_TRANSP = 2'h2;
	localparam logic [1:0] CPWF_WUP_MASK2 = 2'h3;
	// ========================================================================
	// Flag layout: four voltage-failure bits, then two over-current bits; status holds the four voltage-failure bits only.
	localparam int CPWF_NFLAG = 6;
	localparam int CPWF_VF_N = 4;
	localparam int CPWF_VF_HL = 0;
	localparam int CPWF_VF_HH = 1;
	localparam int CPWF_VF_LL = 2;
	localparam int CPWF_VF_LH = 3;
	localparam int CPWF_OC_H = 4;
	localparam int CPWF_OC_L = 5;
	localparam logic [1:0] CPWF_RESP_OKAY = 2'h0;
	localparam logic [1:0] CPWF_RESP_SLVERR = 2'h2;
endpackage

// File: cpwf_wake_if.sv
// Interface between the top and the wake-up filter.
// Assumes one clock domain on aclk.
interface cpwf_wake_if;
	logic stop_mode;
	logic [1:0] wakeup_filter_select;
	logic bus_rx;
	logic rx_out;
	modport ctrl (output stop_mode, output wakeup_filter_select, output bus_rx, input rx_out);
	modport filt (input stop_mode, input wakeup_filter_select, input bus_rx, output rx_out);
endinterface

// File: cpwf_wake_filter.sv
// Stop-mode receive path with wake-up pulse masking.
// Assumes bus_rx is synchronous to aclk, dominant low.
module cpwf_wake_filter (
	input wire logic aclk,
	input wire logic aresetn,
	cpwf_wake_if.filt wk
);
	logic [1:0] cnt_reg, cnt_next;
	logic prev_reg, prev_next;
	logic rx_reg, rx_next;
	logic [1:0] need;

	// ========================================================================
	// Counts dominant pulses after stop entry and passes bus state once enough are masked.
	always_comb begin
		need = (wk.wakeup_filter_select == cpwf_pkg::CPWF_WUP_MASK1) ? 2'h1 :
			(wk.wakeup_filter_select == cpwf_pkg::CPWF_WUP_MASK2) ? 2'h2 : 2'h0;
		cnt_next = cnt_reg;
		prev_next = wk.bus_rx;
		rx_next = wk.bus_rx;
		if (!wk.stop_mode) begin
			cnt_next = 2'h0;
		end else if (wk.wakeup_filter_select == cpwf_pkg::CPWF_WUP_OFF) begin
			rx_next = 1'b1;
		end else if (wk.wakeup_filter_select == cpwf_pkg::CPWF_WUP_TRANSP) begin
			rx_next = wk.bus_rx;
		end else if (cnt_reg < need) begin
			rx_next = 1'b1;
			if (prev_reg && !wk.bus_rx) begin
				cnt_next = cnt_reg + 2'h1;
			end
		end else begin
			// Keeps the tail of the last masked pulse recessive until the bus is released.
			rx_next = (rx_reg && !prev_reg) ? 1'b1 : wk.bus_rx;
		end
	end

	// Registers the filter state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= 2'h0;
			prev_reg <= 1'b1;
			rx_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			prev_reg <= prev_next;
			rx_reg <= rx_next;
		end
	end

	assign wk.rx_out = rx_reg;
endmodule

// File: cpwf_top.sv
// Digital control of a CAN physical layer: wake-up path and bus fault handling.
// Assumes synchronous fault inputs and an AXI4-Lite master on aclk.
module cpwf_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic stop_mode,
	input wire logic bus_rx,
	input wire logic ctl_tx,
	input wire logic [3:0] vfail_in,
	input wire logic [1:0] ocur_in,
	output logic phy_receive_output,
	output logic canh_drive_en,
	output logic canl_drive_en,
	output logic listen_only,
	output logic irq
);
	localparam int NF = cpwf_pkg::CPWF_NFLAG;
	// Widths of the control register, of its wake-up select field and of the status field.
	localparam int CTRL_W = 3;
	localparam int WUP_W = 2;
	localparam int VF_W = cpwf_pkg::CPWF_VF_N;

	logic [2:0] ctrl_reg, ctrl_next;
	logic [3:0] vf_reg, vf_next;
	logic [NF-1:0] flag_reg, flag_next;
	logic [NF-1:0] mask_reg, mask_next;
	// Write side: held address and data, their one-cycle ready pulses, and the response.
	logic aw_reg, aw_next;
	logic w_reg, w_next;
	logic awrdy_reg, awrdy_next;
	logic wrdy_reg, wrdy_next;
	logic ws_reg, ws_next;
	logic b_reg, b_next;
	// Read side: address ready pulse and the held read answer.
	logic ar_reg, ar_next;
	logic r_reg, r_next;
	logic [7:0] awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next;
	logic [31:0] rd_reg, rd_next;
	logic [1:0] br_reg, br_next;
	logic [1:0] rr_reg, rr_next;
	// Driver enables, listen-only and the interrupt line.
	logic hen_reg, hen_next;
	logic len_reg, len_next;
	logic lo_reg, lo_next;
	logic irq_reg, irq_next;
	// Per-cycle fault events, write-one clears and bus transfer strobes.
	logic [NF-1:0] set_ev;
	logic [NF-1:0] clr_mask;
	logic wr_fire;
	logic rd_fire;
	logic flag_read;
	// Driver decision terms.
	logic vf_high;
	logic oc_block;
	logic drv_on;

	// Carrier between the top and the wake-up filter.
	cpwf_wake_if wk();

	// Decodes whether a byte address hits a mapped register.
	function automatic logic cpwf_mapped(input logic [7:0] a);
		cpwf_mapped = (a == cpwf_pkg::CPWF_OFS_CTRL) || (a == cpwf_pkg::CPWF_OFS_STAT) ||
			(a == cpwf_pkg::CPWF_OFS_FLAG) || (a == cpwf_pkg::CPWF_OFS_MASK);
	endfunction

	// ========================================================================
	// Wake-up path; stop entry is the actual stop signal, wake-up goes to the controller.
	// Masking starts from the real stop input, so the window between sleep acknowledge
	// and stop entry is left to the controller's own low-pass filter.
	assign wk.stop_mode = stop_mode;
	assign wk.wakeup_filter_select = ctrl_reg[cpwf_pkg::CPWF_CTRL_WUP_LSB +: WUP_W];
	assign wk.bus_rx = bus_rx;

	// Stop-mode receive filter.
	cpwf_wake_filter cpwf_wake_filter_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.wk(wk)
	);

	// ========================================================================
	// Fault events and driver enables.
	// A voltage-failure event is any change of a line condition against its status bit.
	// Over-current counts only while this device drives dominant, so a fault on an idle
	// bus cannot lock the driver off; the driver enables update on the same edge as the flags.
	always_comb begin
		set_ev = '0;
		for (int i = 0; i < cpwf_pkg::CPWF_VF_N; i++) begin
			set_ev[i] = vfail_in[i] != vf_reg[i];
		end
		set_ev[cpwf_pkg::CPWF_OC_H] = ocur_in[0] && !ctl_tx && hen_reg;
		set_ev[cpwf_pkg::CPWF_OC_L] = ocur_in[1] && !ctl_tx && len_reg;
		vf_high = vfail_in[cpwf_pkg::CPWF_VF_HH] || vfail_in[cpwf_pkg::CPWF_VF_LH];
		oc_block = flag_next[cpwf_pkg::CPWF_OC_H] || flag_next[cpwf_pkg::CPWF_OC_L];
		drv_on = ctrl_reg[cpwf_pkg::CPWF_CTRL_EN_BIT] && !vf_high && !oc_block;
		vf_next = vfail_in;
		hen_next = drv_on;
		len_next = drv_on && !vfail_in[cpwf_pkg::CPWF_VF_LL];
		lo_next = !drv_on;
	end

	// ========================================================================
	// AXI4-Lite slave: address and data taken in either order, one of each outstanding.
	// Each channel is held in its own flag; its ready is a one-cycle pulse, so a second
	// address offered while the data is still awaited is not accepted unseen.
	// The byte-lane strobe is latched with the data because the master may drop it
	// once the data handshake is done, before the write itself lands.
	// Reads answer from registers; a flag read clears the voltage-change flags.
	always_comb begin
		aw_next = aw_reg;
		w_next = w_reg;
		awrdy_next = 1'b0;
		wrdy_next = 1'b0;
		ws_next = ws_reg;
		awa_next = awa_reg;
		wd_next = wd_reg;
		b_next = b_reg;
		br_next = br_reg;
		ar_next = ar_reg;
		r_next = r_reg;
		rd_next = rd_reg;
		rr_next = rr_reg;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		clr_mask = '0;
		flag_read = 1'b0;
		if (s_axi_awvalid && !aw_reg && !b_reg) begin
			aw_next = 1'b1;
			awrdy_next = 1'b1;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_reg && !b_reg) begin
			w_next = 1'b1;
			wrdy_next = 1'b1;
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb[0];
		end
		wr_fire = aw_reg && w_reg && !b_reg;
		if (wr_fire) begin
			aw_next = 1'b0;
			w_next = 1'b0;
			b_next = 1'b1;
			br_next = cpwf_mapped(awa_reg) ? cpwf_pkg::CPWF_RESP_OKAY : cpwf_pkg::CPWF_RESP_SLVERR;
			if (ws_reg) begin
				unique case (awa_reg)
					cpwf_pkg::CPWF_OFS_CTRL: ctrl_next = wd_reg[CTRL_W-1:0];
					cpwf_pkg::CPWF_OFS_FLAG: clr_mask = wd_reg[NF-1:0];
					cpwf_pkg::CPWF_OFS_MASK: mask_next = wd_reg[NF-1:0];
					default: ;
				endcase
			end
		end else if (b_reg && s_axi_bready) begin
			b_next = 1'b0;
		end
		rd_fire = s_axi_arvalid && !ar_reg && !r_reg;
		ar_next = rd_fire;
		if (rd_fire) begin
			r_next = 1'b1;
			rr_next = cpwf_mapped(s_axi_araddr) ? cpwf_pkg::CPWF_RESP_OKAY :
				cpwf_pkg::CPWF_RESP_SLVERR;
			rd_next = '0;
			unique case (s_axi_araddr)
				cpwf_pkg::CPWF_OFS_CTRL: rd_next[CTRL_W-1:0] = ctrl_reg;
				cpwf_pkg::CPWF_OFS_STAT: rd_next[VF_W-1:0] = vf_reg;
				cpwf_pkg::CPWF_OFS_FLAG: begin
					rd_next[NF-1:0] = flag_reg;
					flag_read = 1'b1;
				end
				cpwf_pkg::CPWF_OFS_MASK: rd_next[NF-1:0] = mask_reg;
				default: ;
			endcase
		end else if (r_reg && s_axi_rready) begin
			r_next = 1'b0;
		end
	end

	// ========================================================================
	// Sticky flags: read clears voltage flags, write-one clears; a new event wins.
	// Over-current flags ignore the read clear, so only a deliberate write of one
	// re-enables the driver after an over-current.
	always_comb begin
		flag_next = flag_reg;
		if (flag_read) begin
			flag_next[cpwf_pkg::CPWF_VF_N-1:0] = '0;
		end
		flag_next = (flag_next & ~clr_mask) | set_ev;
		irq_next = |(flag_next & mask_reg);
	end

	// ========================================================================
	// State registers, one block for each group of state.
	// Every register runs on every edge; reset loads constants only.
	// Fault tracking and driver enables; listen-only is set out of reset so the
	// transmitter stays quiet until software enables normal mode.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vf_reg <= '0;
			hen_reg <= 1'b0;
			len_reg <= 1'b0;
			lo_reg <= 1'b1;
		end else begin
			vf_reg <= vf_next;
			hen_reg <= hen_next;
			len_reg <= len_next;
			lo_reg <= lo_next;
		end
	end

	// Sticky flags and the interrupt line.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			irq_reg <= irq_next;
		end
	end

	// Register bus handshake, held requests and the registers that software writes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= cpwf_pkg::CPWF_CTRL_RST;
			mask_reg <= '0;
			aw_reg <= 1'b0;
			w_reg <= 1'b0;
			awrdy_reg <= 1'b0;
			wrdy_reg <= 1'b0;
			ws_reg <= 1'b0;
			b_reg <= 1'b0;
			ar_reg <= 1'b0;
			r_reg <= 1'b0;
			awa_reg <= '0;
			wd_reg <= '0;
			rd_reg <= '0;
			br_reg <= '0;
			rr_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			aw_reg <= aw_next;
			w_reg <= w_next;
			awrdy_reg <= awrdy_next;
			wrdy_reg <= wrdy_next;
			ws_reg <= ws_next;
			b_reg <= b_next;
			ar_reg <= ar_next;
			r_reg <= r_next;
			awa_reg <= awa_next;
			wd_reg <= wd_next;
			rd_reg <= rd_next;
			br_reg <= br_next;
			rr_reg <= rr_next;
		end
	end

	// ========================================================================
	// Outputs straight from flip-flops; wake-up reaches the controller on the receive line.
	// Ready outputs are the one-cycle take pulses, not the held-request flags.
	assign s_axi_awready = awrdy_reg;
	assign s_axi_wready = wrdy_reg;
	assign s_axi_bvalid = b_reg;
	assign s_axi_bresp = br_reg;
	assign s_axi_arready = ar_reg;
	assign s_axi_rvalid = r_reg;
	assign s_axi_rdata = rd_reg;
	assign s_axi_rresp = rr_reg;
	assign phy_receive_output = wk.rx_out;
	assign canh_drive_en = hen_reg;
	assign canl_drive_en = len_reg;
	assign listen_only = lo_reg;
	assign irq = irq_reg;
endmodule

// File: cpwf_assertions.sv
// Checker of the CAN physical layer control block, watching its top ports only.
// Assumes aclk with the synchronous active-low aresetn.
module cpwf_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic stop_mode,
	input wire logic bus_rx,
	input wire logic ctl_tx,
	input wire logic [3:0] vfail_in,
	input wire logic [1:0] ocur_in,
	input wire logic phy_receive_output,
	input wire logic canh_drive_en,
	input wire logic canl_drive_en,
	input wire logic listen_only
);
	// ========================================================================
	// Fault, receive path and bus handshake properties.
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_vfh_off: assert property (
		(vfail_in[1] | vfail_in[3]) |=> listen_only && !canh_drive_en && !canl_drive_en)
		else $error("driver stays on during a high failure");
	a_ocur_off: assert property (
		((ocur_in[0] && canh_drive_en) || (ocur_in[1] && canl_drive_en)) && !ctl_tx
		|-> ##[1:2] listen_only)
		else $error("over-current left the driver on");
	a_canl_low: assert property (
		vfail_in[2] |=> !canl_drive_en)
		else $error("low line driver on during its low failure");
	a_lo_drv: assert property (
		listen_only |-> !canh_drive_en && !canl_drive_en)
		else $error("driver on in listen-only");
	a_rx_follow: assert property (
		!stop_mode && !$past(stop_mode) && $past(aresetn) |-> phy_receive_output == $past(bus_rx))
		else $error("receive output does not follow the bus");
	a_rx_no_fake: assert property (
		!phy_receive_output && $past(aresetn) |-> !$past(bus_rx))
		else $error("dominant shown with the bus recessive");
	a_aw_pulse: assert property (
		s_axi_awready |=> !s_axi_awready)
		else $error("write address ready longer than one cycle");
	a_r_answer: assert property (
		s_axi_arvalid && s_axi_arready |-> s_axi_rvalid)
		else $error("read taken without data");
	c_vfh: cover property (vfail_in[1] ##1 listen_only);
	c_ocur: cover property (ocur_in[0] && !ctl_tx && canh_drive_en);
	c_wake: cover property (stop_mode && !phy_receive_output);
endmodule
bind cpwf_top cpwf_assertions cpwf_assertions_i (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awready(s_axi_awready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.stop_mode(stop_mode),
	.bus_rx(bus_rx),
	.ctl_tx(ctl_tx),
	.vfail_in(vfail_in),
	.ocur_in(ocur_in),
	.phy_receive_output(phy_receive_output),
	.canh_drive_en(canh_drive_en),
	.canl_drive_en(canl_drive_en),
	.listen_only(listen_only)
);

// File: cpwf_can_model.sv
// Far-side model: protocol controller transmit line and the shared bus.
// Assumes the bench asks for dominant bits through tx_dom and remote_dom.
module cpwf_can_model (
	input wire logic aclk,
	input wire logic canh_drive_en,
	input wire logic tx_dom,
	input wire logic remote_dom,
	output logic ctl_tx,
	output logic bus_rx = 1'h1
);
	// ========================================================================
	// Wired bus: recessive high unless a node drives dominant.
	assign ctl_tx = !tx_dom;
	always @(posedge aclk)
		bus_rx <= !(remote_dom || (tx_dom && canh_drive_en));
endmodule

// File: can_phy_wakeup_fault_ctrl_tb_top.sv
// Testbench of the CAN physical layer wake-up and fault control block.
// Assumes the design, checker and far-side model are compiled before it.
module can_phy_wakeup_fault_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'h0, aresetn = 1'h0, stop_mode = 1'h0, tx_dom = 1'h0, remote_dom = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
	logic [3:0] s_axi_wstrb = 4'hF, vfail_in = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br, ocur_in = 2'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_rx, ctl_tx, phy_receive_output;
	logic canh_drive_en, canl_drive_en, listen_only, irq;
	int errors = 0, n_tests = 0;
	cpwf_top cpwf_top_i (.*);
	cpwf_can_model cpwf_can_model_i (.*);
	// ========================================================================
	// Clock, shared tasks and scenarios.
	always #10 aclk = ~aclk;
	task automatic test_done;
		if (errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	// Write and read each hold their request until the slave takes it.
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		br = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		rd_v = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// One remote dominant pulse; reports whether the receive output went low.
	task automatic pulse(output logic s);
		s = 1'h0;
		for (int k = 0; k < 8; k++) begin
			remote_dom <= (k < 3);
			cyc(1);
			s |= !phy_receive_output;
		end
	endtask
	task automatic t_regs;
		rd(8'h00);
		chk("ctrl_reset", 32'h0, rd_v);
		chk("listen_reset", 32'h1, listen_only);
		rd(8'h10);
		chk("unmapped_resp", 32'h2, rr);
		chk("unmapped_data", 32'h0, rd_v);
		wr(8'h10, 32'h7);
		chk("unmapped_wresp", 32'h2, br);
		wr(8'h0C, 32'h3F);
		chk("mask_wresp", 32'h0, br);
		rd(8'h0C);
		chk("mask_read", 32'h3F, rd_v);
		wr(8'h00, 32'h4);
		cyc(3);
		chk("drv_on", 32'h1, canh_drive_en);
	endtask
	task automatic t_vfail;
		vfail_in <= 4'h2;
		cyc(3);
		chk("listen_vfh", 32'h1, listen_only);
		chk("irq_vfh", 32'h1, irq);
		rd(8'h04);
		chk("stat_vfh", 32'h2, rd_v);
		rd(8'h08);
		chk("flag_vfh", 32'h2, rd_v);
		vfail_in <= 4'h0;
		cyc(3);
		chk("drv_back", 32'h1, canh_drive_en);
		rd(8'h08);
		chk("flag_fall", 32'h2, rd_v);
		cyc(2);
		chk("irq_clear", 32'h0, irq);
	endtask
	task automatic t_canl;
		vfail_in <= 4'h4;
		cyc(3);
		chk("canl_off", 32'h0, canl_drive_en);
		chk("canh_kept", 32'h1, canh_drive_en);
		vfail_in <= 4'h0;
		cyc(3);
		rd(8'h08);
		chk("flag_vfl", 32'h4, rd_v);
	endtask
	task automatic t_ocur;
		ocur_in <= 2'h1;
		cyc(3);
		chk("oc_recessive", 32'h0, listen_only);
		tx_dom <= 1'h1;
		cyc(3);
		chk("oc_dominant", 32'h1, listen_only);
		ocur_in <= 2'h0;
		tx_dom <= 1'h0;
		cyc(3);
		chk("oc_hold", 32'h1, listen_only);
		rd(8'h08);
		chk("flag_oc", 32'h10, rd_v);
		wr(8'h08, 32'h10);
		cyc(3);
		chk("oc_back", 32'h0, listen_only);
	endtask
	task automatic t_wake(logic [1:0] sel);
		int nm;
		logic s;
		nm = (sel == 2'h1) ? 1 : (sel == 2'h3) ? 2 : 0;
		wr(8'h00, {29'h0, 1'h1, sel});
		pulse(s);
		stop_mode <= 1'h1;
		cyc(2);
		for (int i = 0; i < 3; i++) begin
			pulse(s);
			chk("rx_stop", {31'h0, sel != 2'h0 && i >= nm}, s);
		end
		stop_mode <= 1'h0;
		cyc(2);
		chk("irq_wake", 32'h0, irq);
	endtask
	// Main sequence after a reset of 12 cycles.
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_vfail();
		t_canl();
		t_ocur();
		for (int s = 0; s < 4; s++)
			t_wake(s[1:0]);
		test_done();
	end
	// Watchdog well beyond the expected run of under a thousand cycles.
	initial begin
		#300000;
		errors++;
		test_done();
	end
endmodule
